/* File: hw/bsp_pkg.sv */
`default_nettype none
package bsp_pkg;
   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int DATA_W = 18;
   localparam int LANE_W = 9;
   localparam int LANES  = 2;
   localparam int ADDR_W = 20;
   localparam int BEAT_W = 2;
   localparam int BURST  = 4;
   localparam int SLOTS  = 2;
   localparam int CNT_W  = 12;
   localparam int SYNC_W = 3;

   // -----------------------------------------------------------------
   // burst beat indices
   // -----------------------------------------------------------------
   localparam logic [BEAT_W-1:0] BEAT_A = 2'h0;
   localparam logic [BEAT_W-1:0] BEAT_B = 2'h1;
   localparam logic [BEAT_W-1:0] BEAT_C = 2'h2;
   localparam logic [BEAT_W-1:0] BEAT_D = 2'h3;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int STOP_NS       = 30;
   localparam int STOP_CYC      = (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] IDLE_MAX = 3'(STOP_CYC);
   localparam logic [CNT_W-1:0] IMPED_CYC     = 12'h400;
   localparam logic [CNT_W-1:0] RESTART_CYC   = 12'h400;
   localparam logic [CNT_W-1:0] LOCK_INTERVAL = 12'h800;

   typedef enum logic [1:0] {
      ST_STOP = 2'b00,
      ST_LOCK = 2'b01,
      ST_RUN  = 2'b10
   } bsp_init_e;
endpackage
`default_nettype wire

/* File: hw/bsp_sync2.sv */
`default_nettype none
// two-flop level synchroniser; nothing may read meta_r
module bsp_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      meta_r <= d;
      q      <= meta_r;
   end
endmodule
`default_nettype wire

/* File: hw/bsp_cnt.sv */
`default_nettype none
// saturating event counter with restart
module bsp_cnt (
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic                      clear,
   input  wire logic                      step,
   input  wire logic [bsp_pkg::CNT_W-1:0] limit,
   output logic                           done
);
   logic [bsp_pkg::CNT_W-1:0] count_r;

   always_ff @(posedge clk) begin
      if (reset || clear) begin
         count_r <= '0;
      end else if (step && !done) begin
         count_r <= count_r + 1'b1;
      end
   end

   assign done = (count_r >= limit);
endmodule
`default_nettype wire

/* File: hw/bsp_port.sv */
`default_nettype none
// -----------------------------------------------------------------
// burst-of-four common-io sram port
// -----------------------------------------------------------------
module bsp_port (
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic                        kClk,
   input  wire logic                        loadStrobeN,
   input  wire logic                        rwSel,
   input  wire logic [bsp_pkg::ADDR_W-1:0]  addr,
   input  wire logic [bsp_pkg::LANES-1:0]   byteWriteMaskN,
   input  wire logic [bsp_pkg::DATA_W-1:0]  sharedDataBusIn,
   output logic      [bsp_pkg::DATA_W-1:0]  sharedDataBusOut,
   output logic                             sharedDataBusOe,
   output logic                             echoStrobePos,
   output logic                             echoStrobeNeg,
   input  wire logic                        dllEnable,
   output logic                             deviceReady,
   output logic                             impedanceSettled
);
   localparam int AW = bsp_pkg::ADDR_W;
   localparam int BW = bsp_pkg::BEAT_W;
   localparam int DW = bsp_pkg::DATA_W;
   localparam int LW = bsp_pkg::LANE_W;
   localparam int NL = bsp_pkg::LANES;

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic [bsp_pkg::SYNC_W-1:0] sysSync;
   logic [1:0]                 edgeHist_r;
   logic                       kPosEdge;
   logic                       kAnyEdge;
   logic                       dllEnS;
   logic                       dllEnD_r;
   logic                       dllRise;
   logic [2:0]                 idle_r;
   logic                       clkParked;
   bsp_pkg::bsp_init_e         state_r;
   bsp_pkg::bsp_init_e         state_nxt;
   logic                       restartLock;
   logic                       lockDone;
   logic                       deviceReady_r;

   logic          kRst;
   logic          kReady;
   logic          kDllOn;
   logic          posTog_r;
   logic          negTog_r;
   logic          hiPhase;
   logic          cmdTake;
   logic          readCmd;
   logic          writeCmd;
   logic          commitNow;
   logic [3:1]    rdS_r;
   logic [3:1]    wrS_r;
   logic [3:1]    slotS_r;
   logic [AW-1:0] aS_r [1:3];

   logic                       wrPtr_r;
   logic [bsp_pkg::SLOTS-1:0]  slotV_r;
   logic [AW-1:0]              slotA_r [bsp_pkg::SLOTS];
   logic [DW-1:0]              evD_r [bsp_pkg::SLOTS][2];
   logic [NL-1:0]              evM_r [bsp_pkg::SLOTS][2];
   logic [DW-1:0]              odD_r [bsp_pkg::SLOTS][2];
   logic [NL-1:0]              odM_r [bsp_pkg::SLOTS][2];
   logic [DW-1:0]              mem   [2**AW];

   logic [DW-1:0] dqP_r;
   logic [DW-1:0] dqN_r;
   logic          oeP_r;
   logic          oeN_r;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [AW-1:0] bAddr(
      input logic [AW-1:0] a,
      input logic [BW-1:0] k);
      bAddr = {a[AW-1:BW], BW'(a[BW-1:0] + k)};
   endfunction

   // oldest slot first so the newest write wins each byte
   function automatic logic [DW-1:0] rdWord(input logic [AW-1:0] wa);
      logic [DW-1:0] w;
      logic [DW-1:0] d;
      logic [NL-1:0] m;
      logic          s;
      logic [BW-1:0] k;
      w = mem[wa];
      for (int i = 0; i < bsp_pkg::SLOTS; i++) begin
         s = wrPtr_r ^ i[0];
         k = BW'(wa[BW-1:0] - slotA_r[s][BW-1:0]);
         d = k[0] ? odD_r[s][k[1]] : evD_r[s][k[1]];
         m = k[0] ? odM_r[s][k[1]] : evM_r[s][k[1]];
         if (slotV_r[s] && slotA_r[s][AW-1:BW] == wa[AW-1:BW]) begin
            for (int j = 0; j < NL; j++) begin
               if (m[j]) begin
                  w[j*LW +: LW] = d[j*LW +: LW];
               end
            end
         end
      end
      rdWord = w;
   endfunction

   // -----------------------------------------------------------------
   // system domain: clock activity, dll and impedance sequencing
   // -----------------------------------------------------------------
   bsp_sync2 #(.W(bsp_pkg::SYNC_W)) uSyncSys (
      .clk (clk),
      .d   ({posTog_r, negTog_r, dllEnable}),
      .q   (sysSync)
   );

   assign dllEnS   = sysSync[0];
   assign kPosEdge = sysSync[2] ^ edgeHist_r[1];
   assign kAnyEdge = |(sysSync[2:1] ^ edgeHist_r);
   assign dllRise  = dllEnS && !dllEnD_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         edgeHist_r <= '0;
         dllEnD_r   <= 1'b0;
      end else begin
         edgeHist_r <= sysSync[2:1];
         dllEnD_r   <= dllEnS;
      end
   end

   // both k edges are watched so a 24 ns half period never looks parked;
   // a k half period longer than about 50 ns would read as stopped
   always_ff @(posedge clk) begin
      if (reset || kAnyEdge) begin
         idle_r <= '0;
      end else if (idle_r != 3'h7) begin
         idle_r <= idle_r + 3'h1;
      end
   end

   assign clkParked = (idle_r > bsp_pkg::IDLE_MAX) && !kAnyEdge;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         bsp_pkg::ST_STOP: begin
            if (kAnyEdge) state_nxt = bsp_pkg::ST_LOCK;
         end
         bsp_pkg::ST_LOCK: begin
            if (lockDone) state_nxt = bsp_pkg::ST_RUN;
         end
         bsp_pkg::ST_RUN: begin
            state_nxt = bsp_pkg::ST_RUN;
         end
         default: begin
            state_nxt = bsp_pkg::ST_STOP;
         end
      endcase
      if (clkParked) begin
         state_nxt = bsp_pkg::ST_STOP;
      end else if (dllRise) begin
         state_nxt = bsp_pkg::ST_LOCK;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= bsp_pkg::ST_STOP;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign restartLock = (state_nxt == bsp_pkg::ST_LOCK) &&
                        (state_r != bsp_pkg::ST_LOCK || dllRise);

   // bypassed dll skips locking but logic still needs its restart time
   bsp_cnt uLock (
      .clk   (clk),
      .reset (reset),
      .clear (restartLock),
      .step  (kPosEdge),
      .limit (dllEnS ? bsp_pkg::LOCK_INTERVAL : bsp_pkg::RESTART_CYC),
      .done  (lockDone)
   );

   bsp_cnt uImped (
      .clk   (clk),
      .reset (reset),
      .clear (1'b0),
      .step  (kPosEdge),
      .limit (bsp_pkg::IMPED_CYC),
      .done  (impedanceSettled)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         deviceReady_r <= 1'b0;
      end else begin
         deviceReady_r <= (state_nxt == bsp_pkg::ST_RUN) && impedanceSettled;
      end
   end

   assign deviceReady = deviceReady_r;

   // -----------------------------------------------------------------
   // link domain: command decode and pipeline
   // -----------------------------------------------------------------
   bsp_sync2 #(.W(bsp_pkg::SYNC_W)) uSyncLink (
      .clk (kClk),
      .d   ({reset, deviceReady_r, dllEnS}),
      .q   ({kRst, kReady, kDllOn})
   );

   assign cmdTake   = kReady && !loadStrobeN;
   assign readCmd   = cmdTake && rwSel;
   assign writeCmd  = cmdTake && !rwSel;
   assign commitNow = writeCmd && slotV_r[wrPtr_r];

   // one command per two cycles keeps the stages from colliding
   always_ff @(posedge kClk) begin
      if (kRst) begin
         rdS_r   <= '0;
         wrS_r   <= '0;
         slotS_r <= '0;
      end else begin
         rdS_r   <= {rdS_r[2:1], readCmd};
         wrS_r   <= {wrS_r[2:1], writeCmd};
         slotS_r <= {slotS_r[2:1], wrPtr_r};
      end
   end

   always_ff @(posedge kClk) begin
      aS_r[1] <= addr;
      aS_r[2] <= aS_r[1];
      aS_r[3] <= aS_r[2];
   end

   // -----------------------------------------------------------------
   // late-write buffers
   // -----------------------------------------------------------------
   always_ff @(posedge kClk) begin
      if (kRst) begin
         wrPtr_r <= 1'b0;
         slotV_r <= '0;
      end else if (writeCmd) begin
         slotV_r[wrPtr_r] <= 1'b1;
         wrPtr_r          <= ~wrPtr_r;
      end
   end

   always_ff @(posedge kClk) begin
      if (writeCmd) begin
         slotA_r[wrPtr_r] <= addr;
      end
   end

   // beats one and three on the k rise
   always_ff @(posedge kClk) begin
      if (wrS_r[1]) begin
         evD_r[slotS_r[1]][0] <= sharedDataBusIn;
         evM_r[slotS_r[1]][0] <= ~byteWriteMaskN;
      end
      if (wrS_r[2]) begin
         evD_r[slotS_r[2]][1] <= sharedDataBusIn;
         evM_r[slotS_r[2]][1] <= ~byteWriteMaskN;
      end
   end

   // beats two and four on the k fall
   always_ff @(negedge kClk) begin
      if (wrS_r[2]) begin
         odD_r[slotS_r[2]][0] <= sharedDataBusIn;
         odM_r[slotS_r[2]][0] <= ~byteWriteMaskN;
      end
      if (wrS_r[3]) begin
         odD_r[slotS_r[3]][1] <= sharedDataBusIn;
         odM_r[slotS_r[3]][1] <= ~byteWriteMaskN;
      end
   end

   // the oldest burst is retired only when a third write needs its slot
   always_ff @(posedge kClk) begin
      if (commitNow) begin
         for (int k = 0; k < bsp_pkg::BURST; k++) begin
            for (int j = 0; j < NL; j++) begin
               if (k[0] ? odM_r[wrPtr_r][k[1]][j] : evM_r[wrPtr_r][k[1]][j]) begin
                  mem[bAddr(slotA_r[wrPtr_r], BW'(k))][j*LW +: LW] <=
                     k[0] ? odD_r[wrPtr_r][k[1]][j*LW +: LW]
                          : evD_r[wrPtr_r][k[1]][j*LW +: LW];
               end
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // read data and echo strobes
   // -----------------------------------------------------------------
   always_ff @(posedge kClk) begin
      if (kRst) begin
         posTog_r <= 1'b0;
      end else begin
         posTog_r <= ~negTog_r;
      end
   end

   always_ff @(negedge kClk) begin
      if (kRst) begin
         negTog_r <= 1'b0;
      end else begin
         negTog_r <= posTog_r;
      end
   end

   assign hiPhase = posTog_r ^ negTog_r;

   always_ff @(posedge kClk) begin
      if (kRst) begin
         oeP_r <= 1'b0;
         dqP_r <= '0;
      end else if (kDllOn && rdS_r[2]) begin
         oeP_r <= 1'b1;
         dqP_r <= rdWord(bAddr(aS_r[2], bsp_pkg::BEAT_B));
      end else if (kDllOn && rdS_r[3]) begin
         oeP_r <= 1'b1;
         dqP_r <= rdWord(bAddr(aS_r[3], bsp_pkg::BEAT_D));
      end else if (!kDllOn && rdS_r[1]) begin
         oeP_r <= 1'b1;
         dqP_r <= rdWord(bAddr(aS_r[1], bsp_pkg::BEAT_A));
      end else if (!kDllOn && rdS_r[2]) begin
         oeP_r <= 1'b1;
         dqP_r <= rdWord(bAddr(aS_r[2], bsp_pkg::BEAT_C));
      end else begin
         oeP_r <= 1'b0;
      end
   end

   always_ff @(negedge kClk) begin
      if (kRst) begin
         oeN_r <= 1'b0;
         dqN_r <= '0;
      end else if (rdS_r[2]) begin
         oeN_r <= 1'b1;
         dqN_r <= rdWord(bAddr(aS_r[2], kDllOn ? bsp_pkg::BEAT_A
                                               : bsp_pkg::BEAT_B));
      end else if (rdS_r[3]) begin
         oeN_r <= 1'b1;
         dqN_r <= rdWord(bAddr(aS_r[3], kDllOn ? bsp_pkg::BEAT_C
                                               : bsp_pkg::BEAT_D));
      end else begin
         oeN_r <= 1'b0;
      end
   end

   // single-clock mode only: k edges stand in for the output clocks
   assign sharedDataBusOut = hiPhase ? dqP_r : dqN_r;
   assign sharedDataBusOe  = hiPhase ? oeP_r : oeN_r;
   assign echoStrobePos    = hiPhase;
   assign echoStrobeNeg    = ~hiPhase;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   sequence s_wrPipe;
      wrS_r[1] ##1 wrS_r[2] ##1 wrS_r[3];
   endsequence

   sequence s_oeBoth2;
      (oeP_r && oeN_r) [*2];
   endsequence

   a_read_fall_beats: assert property (@(posedge kClk) disable iff (kRst)
      readCmd && kDllOn |-> ##2 oeN_r [*2])
      else $error("read beats missing on k fall");

   a_read_rise_beats: assert property (@(posedge kClk) disable iff (kRst)
      readCmd && kDllOn |-> ##3 oeP_r [*2])
      else $error("read beats missing on k rise");

   a_legacy_beats: assert property (@(posedge kClk) disable iff (kRst)
      readCmd && !kDllOn |-> ##2 s_oeBoth2)
      else $error("dll-off read latency wrong");

   a_nop_hiz: assert property (@(posedge kClk) disable iff (kRst)
      rdS_r == '0 |=> !oeP_r)
      else $error("driver left on without read");

   a_commit_third: assert property (@(posedge kClk) disable iff (kRst)
      commitNow |-> slotV_r[~wrPtr_r] && writeCmd)
      else $error("commit before third write");

   a_read_no_commit: assert property (@(posedge kClk) disable iff (kRst)
      readCmd |-> !commitNow)
      else $error("read changed memory");

   a_write_beats: assert property (@(posedge kClk) disable iff (kRst)
      writeCmd |=> s_wrPipe)
      else $error("write beat capture out of step");

   a_nop_no_take: assert property (@(posedge kClk) disable iff (kRst)
      loadStrobeN |=> !rdS_r[1] && !wrS_r[1])
      else $error("command taken with load strobe high");

   // the link reset is unknown until its synchroniser has filled
   a_echo_low: assert property (@(posedge kClk) disable iff (reset || kRst)
      !echoStrobePos)
      else $error("echo strobe out of phase");

   a_dll_drop: assert property (@(posedge clk) disable iff (reset)
      dllRise |=> !deviceReady_r)
      else $error("ready kept through dll reset");

   a_stop_drop: assert property (@(posedge clk) disable iff (reset)
      clkParked |=> !deviceReady_r [*2])
      else $error("ready kept through clock stop");

   a_ready_rise: assert property (@(posedge clk) disable iff (reset)
      $rose(deviceReady_r) |-> $past(lockDone) && impedanceSettled)
      else $error("ready before lock and impedance");
endmodule
`default_nettype wire

/* File: bench/bsp_master_model.sv */
`default_nettype none
// ---------------------------------------------
// memory controller side of the link
// ---------------------------------------------
module bsp_master_model (
   output logic                          kClk,
   output logic                          loadStrobeN,
   output logic                          rwSel,
   output logic [bsp_pkg::ADDR_W-1:0]    addr,
   output logic [bsp_pkg::LANES-1:0]     byteWriteMaskN,
   output logic [bsp_pkg::DATA_W-1:0]    sharedDataBusIn,
   input  wire logic [bsp_pkg::DATA_W-1:0] sharedDataBusOut,
   input  wire logic                     sharedDataBusOe
);
   timeunit 1ns;
   timeprecision 100ps;
   bit kRun = 1'b1;
   initial begin
      loadStrobeN = 1'b1;
      rwSel = 1'b1;
      addr = '0;
      byteWriteMaskN = '1;
      sharedDataBusIn = '0;
   end
   // parks at whatever level it had, like a stopped clock pair
   // single-clock mode: output clocks stay tied high, only the k pair switches
   initial begin
      kClk = 1'b0;
      forever begin
         #24;
         if (kRun) kClk = ~kClk;
      end
   end
   // each command returns late enough that the next is two k cycles away
   task automatic issue(input logic rd, input logic [bsp_pkg::ADDR_W-1:0] a);
      @(posedge kClk);
      #12;
      loadStrobeN = 1'b0;
      rwSel = rd;
      addr = a;
      @(posedge kClk);
      #12;
      loadStrobeN = 1'b1;
      rwSel = ~rd;
      addr = ~a;
   endtask
   task automatic write_burst(input logic [bsp_pkg::ADDR_W-1:0] a,
                              input logic [3:0][bsp_pkg::DATA_W-1:0] d,
                              input logic [3:0][bsp_pkg::LANES-1:0] m);
      issue(1'b0, a);
      for (int k = 0; k < 4; k++) begin
         sharedDataBusIn = d[k];
         byteWriteMaskN = m[k];
         if (k % 2 == 0) @(posedge kClk);
         else @(negedge kClk);
         #12;
      end
      sharedDataBusIn = ~d[3];
      byteWriteMaskN = '1;
   endtask
   task automatic read_burst(input logic [bsp_pkg::ADDR_W-1:0] a,
                             input logic legacy,
                             output logic [3:0][bsp_pkg::DATA_W-1:0] q,
                             output logic [3:0] oe,
                             output logic oeAfter);
      issue(1'b1, a);
      // beat one comes one k cycle after the command with the dll off, 1.5 with it on
      repeat (legacy ? 2 : 3) @(kClk);
      for (int k = 0; k < 4; k++) begin
         if (k > 0) @(kClk);
         #12;
         q[k] = sharedDataBusOut;
         oe[k] = sharedDataBusOe;
      end
      @(kClk);
      #12;
      oeAfter = sharedDataBusOe;
   endtask
endmodule
`default_nettype wire

/* File: bench/bsp_port_bench.sv */
`default_nettype none
module bsp_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef logic [3:0][bsp_pkg::DATA_W-1:0] bsp_burst_t;
   logic                        clk;
   logic                        reset;
   logic                        dllEnable;
   logic                        kClk;
   logic                        loadStrobeN;
   logic                        rwSel;
   logic [bsp_pkg::ADDR_W-1:0]  addr;
   logic [bsp_pkg::LANES-1:0]   byteWriteMaskN;
   logic [bsp_pkg::DATA_W-1:0]  sharedDataBusIn;
   logic [bsp_pkg::DATA_W-1:0]  sharedDataBusOut;
   logic                        sharedDataBusOe;
   logic                        echoStrobePos;
   logic                        echoStrobeNeg;
   logic                        deviceReady;
   logic                        impedanceSettled;
   int                          failCount = 0;
   int                          nCompared = 0;
   bsp_port i_bsp_port (.clk(clk), .reset(reset), .kClk(kClk), .loadStrobeN(loadStrobeN),
      .rwSel(rwSel), .addr(addr), .byteWriteMaskN(byteWriteMaskN),
      .sharedDataBusIn(sharedDataBusIn), .sharedDataBusOut(sharedDataBusOut),
      .sharedDataBusOe(sharedDataBusOe), .echoStrobePos(echoStrobePos),
      .echoStrobeNeg(echoStrobeNeg), .dllEnable(dllEnable), .deviceReady(deviceReady),
      .impedanceSettled(impedanceSettled));
   bsp_master_model i_bsp_master_model (.kClk(kClk), .loadStrobeN(loadStrobeN),
      .rwSel(rwSel), .addr(addr), .byteWriteMaskN(byteWriteMaskN),
      .sharedDataBusIn(sharedDataBusIn), .sharedDataBusOut(sharedDataBusOut),
      .sharedDataBusOe(sharedDataBusOe));
   // ---------------------------------------------
   // checking and closing
   // ---------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         failCount++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ready is due within a small margin of the k rise count, 4.8 clk per k rise
   task automatic wait_ready(input string what, input int kRises);
      int n;
      int lo;
      int hi;
      n = 0;
      lo = (kRises - 32) * 48 / 10;
      hi = (kRises + 32) * 48 / 10;
      while (deviceReady !== 1'b1 && n < hi) begin
         @(negedge clk);
         n++;
      end
      check(what, deviceReady, 1'b1);
      check({what, " not early"}, n > lo, 1'b1);
      repeat (4) @(posedge kClk);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_power_up();
      bsp_burst_t q;
      logic [3:0] oe;
      logic oeAfter;
      repeat (20) @(negedge clk);
      dllEnable = 1'b1;
      i_bsp_master_model.read_burst(20'h00010, 1'b0, q, oe, oeAfter);
      check("drive before ready", oe, 4'h0);
      wait_ready("ready after lock", int'(bsp_pkg::LOCK_INTERVAL));
      check("impedance settled", impedanceSettled, 1'b1);
      #12;
      check("echo pos", echoStrobePos, 1'b1);
      check("echo neg", echoStrobeNeg, 1'b0);
   endtask
   task automatic t_buffer_coherence(input logic legacy);
      bsp_burst_t d0, e, q;
      logic [3:0][bsp_pkg::LANES-1:0] mk;
      logic [3:0] oe;
      logic oeAfter;
      logic [bsp_pkg::DATA_W-1:0] mem [4];
      d0 = {18'h00d44, 18'h00c33, 18'h00b22, 18'h00a11};
      e = {18'h0f0f0, 18'h3c3c3, 18'h15a5a, 18'h2a5a5};
      mk = {2'h3, 2'h1, 2'h2, 2'h0};
      for (int k = 0; k < 4; k++) mem[k] = d0[k];
      i_bsp_master_model.write_burst(20'h00010, d0, '0);
      i_bsp_master_model.write_burst(20'h00012, e, mk);
      for (int k = 0; k < 4; k++) begin
         for (int l = 0; l < bsp_pkg::LANES; l++) begin
            if (!mk[k][l]) begin
               mem[(2+k)%4][l*bsp_pkg::LANE_W +: bsp_pkg::LANE_W] =
                  e[k][l*bsp_pkg::LANE_W +: bsp_pkg::LANE_W];
            end
         end
      end
      // first pass reads from the write buffers, second from the array
      for (int p = 0; p < 2; p++) begin
         i_bsp_master_model.read_burst(20'h00011, legacy, q, oe, oeAfter);
         for (int k = 0; k < 4; k++) begin
            check("read beat", q[k], mem[(1+k)%4]);
         end
         check("drive enable", oe, 4'hf);
         check("drive release", oeAfter, 1'b0);
         i_bsp_master_model.write_burst(20'h00020, e, '0);
         i_bsp_master_model.write_burst(20'h00030, e, '0);
      end
   endtask
   // the dll is bypassed across the stop, so the restart skips locking
   task automatic t_clock_stop();
      @(negedge clk);
      dllEnable = 1'b0;
      i_bsp_master_model.kRun = 1'b0;
      repeat (20) @(negedge clk);
      check("ready while parked", deviceReady, 1'b0);
      i_bsp_master_model.kRun = 1'b1;
      wait_ready("ready after restart", int'(bsp_pkg::RESTART_CYC));
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #400000;
      failCount++;
      report_and_stop();
   end
   // reset is held past three k rises so the link side sees it too
   initial begin
      reset = 1'b1;
      dllEnable = 1'b0;
      repeat (16) @(negedge clk);
      check("ready in reset", deviceReady, 1'b0);
      check("impedance in reset", impedanceSettled, 1'b0);
      reset = 1'b0;
      t_power_up();
      t_buffer_coherence(1'b0);
      t_clock_stop();
      t_buffer_coherence(1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire
